// File: hw/wiper_host.sv
// controller that steps, programs and locks an up/down wiper part
// assumes the part's select, step and supply enable pins hang on the outputs
`timescale 1ns/1ps
`default_nettype none

module wiper_host #(
    parameter int PUP_CYC = potctl_pkg::PUP_CYC,
    parameter int PC_CYC  = potctl_pkg::PC_CYC,
    parameter int CL_CYC  = potctl_pkg::CL_CYC,
    parameter int CH_CYC  = potctl_pkg::CH_CYC,
    parameter int PH_CYC  = potctl_pkg::PH_CYC
) (
    input  wire logic                         core_clk_i,
    input  wire logic                         sys_rst_i,
    input  wire logic                         cmd_valid_i,
    input  wire logic [1:0]                   cmd_op_i,
    input  wire logic                         cmd_up_i,
    input  wire logic [potctl_pkg::TAP_W-1:0] cmd_count_i,
    output logic                              cmd_ready_o,
    output logic                              done_o,
    output logic                              locked_o,
    output logic                              sel_n_o,
    output logic                              step_o,
    output logic                              vpp_en_o
);
    localparam int TW = potctl_pkg::TIMER_W;

    // ======================================================================
    // state
    typedef enum logic [11:0] {
        ST_INIT  = 12'h001,
        ST_PWRUP = 12'h002,
        ST_IDLE  = 12'h004,
        ST_SETUP = 12'h008,
        ST_SEL   = 12'h010,
        ST_UDLO  = 12'h020,
        ST_UDHI  = 12'h040,
        ST_DESEL = 12'h080,
        ST_VPPON = 12'h100,
        ST_PLO   = 12'h200,
        ST_PHI   = 12'h400,
        ST_VPPOF = 12'h800
    } state_t;

    typedef struct packed {
        state_t                     st;
        logic                       sel_n;
        logic                       step;
        logic                       vpp;
        logic                       ready;
        logic                       done;
        logic                       locked;
        logic [potctl_pkg::TAP_W-1:0] left;
        logic [2:0]                 pulses;
        logic [2:0]                 target;
    } core_t;

    core_t          r;
    core_t          next_r;
    logic           tmr_load;
    logic [TW-1:0]  tmr_val;
    logic           tmr_zero;

    step_timer #(.W(TW)) u_timer (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .load_i     (tmr_load),
        .value_i    (tmr_val),
        .zero_o     (tmr_zero)
    );

    // ======================================================================
    // sequencer
    always_comb
    begin
        next_r   = r;
        tmr_load = 1'b0;
        tmr_val  = TW'(potctl_pkg::UD_CYC);
        next_r.done = 1'b0;
        unique case (r.st)
            ST_INIT:
            begin
                tmr_load  = 1'b1;
                tmr_val   = TW'(PUP_CYC);
                next_r.st = ST_PWRUP;
            end
            ST_PWRUP:
            if (tmr_zero)                           // R20
            begin
                next_r.ready = 1'b1;
                next_r.st    = ST_IDLE;
            end
            ST_IDLE:
            if (cmd_valid_i)
            begin
                next_r.ready = 1'b0;
                if (r.locked || cmd_op_i == 2'h3)   // R14 R15
                begin
                    // no pin activity; finish through the deselect wait
                    tmr_load  = 1'b1;
                    next_r.st = ST_DESEL;
                end
                else if (cmd_op_i == potctl_pkg::OP_STEP)
                begin
                    if (cmd_count_i == '0)
                    begin
                        // nothing to step, done and ready rise together later
                        tmr_load  = 1'b1;
                        next_r.st = ST_DESEL;
                    end
                    else
                    begin
                        next_r.step = cmd_up_i;     // R2
                        next_r.left = cmd_count_i;
                        tmr_load    = 1'b1;
                        next_r.st   = ST_SETUP;
                    end
                end
                else
                begin
                    // step line high before the supply rises
                    next_r.step   = 1'b1;           // R9
                    next_r.vpp    = 1'b1;
                    next_r.pulses = 3'h0;
                    next_r.target = (cmd_op_i == potctl_pkg::OP_LOCK) ?
                                    potctl_pkg::PULSES_LOCK : potctl_pkg::PULSES_PROG; // R16
                    tmr_load      = 1'b1;
                    tmr_val       = TW'(PC_CYC);    // R18
                    next_r.st     = ST_VPPON;
                end
            end
            ST_SETUP:
            if (tmr_zero)
            begin
                next_r.sel_n = 1'b0;                // R1 R2
                tmr_load     = 1'b1;
                next_r.st    = ST_SEL;
            end
            ST_SEL:
            if (tmr_zero)
            begin
                next_r.step = 1'b0;
                tmr_load    = 1'b1;
                next_r.st   = ST_UDLO;
            end
            ST_UDLO:
            if (tmr_zero)
            begin
                next_r.step = 1'b1;                 // R4
                next_r.left = r.left - 5'h01;
                tmr_load    = 1'b1;
                next_r.st   = ST_UDHI;
            end
            ST_UDHI:
            if (tmr_zero)
            begin
                tmr_load = 1'b1;
                if (r.left == '0)
                begin
                    // deselect with step high: no extra step
                    next_r.sel_n = 1'b1;            // R3 R6
                    next_r.st    = ST_DESEL;
                end
                else
                begin
                    next_r.step = 1'b0;
                    next_r.st   = ST_UDLO;
                end
            end
            ST_DESEL:
            if (tmr_zero)
            begin
                next_r.done  = 1'b1;
                next_r.ready = 1'b1;
                next_r.st    = ST_IDLE;
            end
            ST_VPPON:
            if (tmr_zero)
            begin
                next_r.sel_n = 1'b0;                // R9
                tmr_load     = 1'b1;
                tmr_val      = TW'(CL_CYC);
                next_r.st    = ST_PLO;
            end
            ST_PLO:
            if (tmr_zero)
            begin
                tmr_load = 1'b1;
                if (r.pulses == r.target)
                begin
                    next_r.vpp = 1'b0;              // R11
                    tmr_val    = TW'(PH_CYC);       // R19
                    next_r.st  = ST_VPPOF;
                end
                else
                begin
                    next_r.sel_n = 1'b1;            // R10
                    tmr_val      = TW'(CH_CYC);     // R21
                    next_r.st    = ST_PHI;
                end
            end
            ST_PHI:
            if (tmr_zero)
            begin
                next_r.sel_n  = 1'b0;
                next_r.pulses = r.pulses + 3'h1;    // R10 R13
                tmr_load      = 1'b1;
                tmr_val       = TW'(CL_CYC);        // R21
                next_r.st     = ST_PLO;
            end
            ST_VPPOF:
            if (tmr_zero)
            begin
                next_r.sel_n = 1'b1;
                next_r.locked = r.locked || (r.target == potctl_pkg::PULSES_LOCK); // R13 R15
                tmr_load     = 1'b1;
                next_r.st    = ST_DESEL;
            end
            default:
            begin
                next_r.st = ST_INIT;
            end
        endcase
    end

    // registers, reset leaves the pins idle
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            r       <= '0;
            r.st    <= ST_INIT;
            r.sel_n <= 1'b1;
            r.step  <= 1'b1;
        end
        else
            r <= next_r;
    end

    assign cmd_ready_o = r.ready;
    assign done_o      = r.done;
    assign locked_o    = r.locked;
    assign sel_n_o     = r.sel_n;
    assign step_o      = r.step;
    assign vpp_en_o    = r.vpp;

    // ======================================================================
    // checks: cycles since the last change of select or supply
    logic [TW-1:0] since;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            since <= '0;
        else if (next_r.sel_n != r.sel_n || next_r.vpp != r.vpp)
            since <= TW'(1);
        else if (since != '1)
            since <= since + TW'(1);
    end

    a_quiet_powerup: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (r.st == ST_INIT || r.st == ST_PWRUP) |-> sel_n_o && !vpp_en_o && !cmd_ready_o) // R20
        else $error("pins moved during power-up wait");

    a_supply_setup: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(vpp_en_o) |-> sel_n_o && step_o && $past(step_o)) // R9
        else $error("supply raised without step high and part deselected");

    a_first_fall_gap: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $fell(sel_n_o) && vpp_en_o && r.pulses == 3'h0 && $past(sel_n_o)
        |-> $past(since) >= TW'(PC_CYC)) // R18
        else $error("select fell too soon after supply rise");

    a_prog_high_phase: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $fell(sel_n_o) && vpp_en_o && r.pulses != 3'h0
        |-> $past(since) >= TW'(CH_CYC)) // R21
        else $error("programming high phase too short");

    a_prog_low_phase: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(sel_n_o) && vpp_en_o |-> $past(since) >= TW'(CL_CYC)) // R21
        else $error("programming low phase too short");

    a_pulse_total: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $fell(vpp_en_o) |-> !sel_n_o && r.pulses == r.target
                            && $past(since) >= TW'(CL_CYC)) // R10 R11
        else $error("supply removed with wrong pulse count");

    a_supply_to_desel: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(sel_n_o) && $past(r.st) == ST_VPPOF
        |-> !vpp_en_o && $past(since) >= TW'(PH_CYC)) // R19
        else $error("select rose too soon after supply removal");

    a_desel_step_high: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $rose(sel_n_o) |-> step_o) // R6
        else $error("deselect with step low would add a step");

    a_dir_at_select: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        $fell(sel_n_o) && !vpp_en_o |-> step_o == $past(step_o, 2)) // R2 R3
        else $error("step line moved around the select edge");

    a_locked_idle: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        locked_o && r.st == ST_IDLE && cmd_valid_i |=> (sel_n_o && !vpp_en_o) [*2]) // R14 R15
        else $error("command acted on a locked part");
endmodule : wiper_host

`default_nettype wire

// File: hw/step_timer.sv
// constants shared by the wiper controller, and the wait timer it uses
// assumes one 100 MHz clock and a synchronous active-high reset
//
// Operation
// R1 - the part moves its wiper only while chip select is low
// R2 - chip select falling latches up when step line high, down when low
// R3 - latched direction holds until chip select returns high
// R4 - each step line rising edge while selected moves the wiper one tap
// R5 - chip select rising with step line low adds one more step
// R6 - chip select rising with step line high adds no step
// R7 - the wiper counter saturates at both ends, never wraps
// R8 - an unprogrammed part starts at tap 16 and stays adjustable
// R9 - programming: set tap, step line high, raise supply, then select low
// R10 - five chip select pulses with supply raised store the tap
// R11 - after the pulses the programming supply returns to zero
// R12 - after five-pulse programming the stored tap reloads at power-up
// R13 - a sixth pulse sets a lock that fixes the wiper and interface
// R14 - a locked part ignores chip select and step line entirely
// R15 - after a six-pulse program no further programming is accepted
// R16 - to lock later, return to the stored tap then send six pulses; OP_LOCK sends the six pulses at the current tap without stepping back
// R17 - the wiper addresses 32 taps, a five bit value
// R18 - wait at least 1 ms from supply rise to first select fall
// R19 - wait at least 1 ms from supply removal to select rising
// R20 - no access until 1 ms power-up time has passed
// R21 - each programming high and low phase lasts at least 5 ms
// R22 - the part keeps programmed flag, stored tap and lock flag
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// package
package potctl_pkg;
    localparam int CLK_MHZ       = 100;
    localparam int TAP_W         = 5;      // 32 taps
    localparam int DEFAULT_TAP   = 16;     // tap of an unprogrammed part
    localparam int TIMER_W       = 20;
    // least times in ns and us
    localparam int T_UD_HIGH_NS  = 100;    // least step line high/low time
    localparam int T_PUP_US      = 1000;   // power-up time
    localparam int T_PC_US       = 1000;   // supply rise to select fall
    localparam int T_CL_US       = 5000;   // programming low phase
    localparam int T_CH_US       = 5000;   // programming high phase
    localparam int T_PH_US       = 1000;   // supply fall to select rise
    // cycle counts, least times rounded up
    localparam int UD_CYC        = (T_UD_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int PUP_CYC       = T_PUP_US * CLK_MHZ;
    localparam int PC_CYC        = T_PC_US * CLK_MHZ;
    localparam int CL_CYC        = T_CL_US * CLK_MHZ;
    localparam int CH_CYC        = T_CH_US * CLK_MHZ;
    localparam int PH_CYC        = T_PH_US * CLK_MHZ;
    // pulse counts
    localparam logic [2:0] PULSES_PROG = 3'h5;
    localparam logic [2:0] PULSES_LOCK = 3'h6;
    // command codes
    localparam logic [1:0] OP_STEP = 2'h0;
    localparam logic [1:0] OP_PROG = 2'h1;
    localparam logic [1:0] OP_LOCK = 2'h2;
endpackage : potctl_pkg

// ==========================================================================
// wait timer: load a count, zero_o rises that many cycles later
module step_timer #(
    parameter int W = potctl_pkg::TIMER_W
) (
    input  wire logic         core_clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    output logic              zero_o
);
    typedef struct packed {
        logic [W-1:0] count;
    } tmr_t;

    tmr_t r;
    tmr_t next_r;

    // reload or count down to zero
    always_comb
    begin
        next_r = r;
        if (load_i)
        begin
            next_r.count = value_i;
        end
        else if (r.count != '0)
        begin
            next_r.count = r.count - W'(1);
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            r <= '0;
        else
            r <= next_r;
    end

    assign zero_o = (r.count == '0);

    // a loaded count above 2 stays nonzero for the next two cycles
    a_timer_load_holds: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        load_i && value_i > W'(2) |=> !zero_o [*2])
        else $error("timer expired right after load");
endmodule : step_timer

`default_nettype wire

// File: tb/pot_model.sv
// behavioural model of the up/down wiper part with one-time programming
// assumes pins sampled on the host clock; power_on_i models supply ramp
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// wiper part model
module pot_model (
    input  wire logic       core_clk_i,
    input  wire logic       power_on_i,
    input  wire logic       sel_n_i,
    input  wire logic       step_i,
    input  wire logic       vpp_i,
    output logic [4:0]      tap_o,
    output logic            prog_o,
    output logic            lock_o
);
    logic [4:0] stored;
    logic       up;
    logic [2:0] pulses;
    logic       sel_q;
    logic       step_q;
    logic       vpp_q;

    // nonvolatile cells start blank and survive power cycles
    initial
    begin
        prog_o = 1'b0;
        lock_o = 1'b0;
        stored = 5'h00;
    end

    // one tap in the latched direction, held at both ends
    function automatic logic [4:0] move(input logic [4:0] t, input logic u);
        if (u)
            return (t == 5'h1f) ? t : t + 5'h01;
        return (t == 5'h00) ? t : t - 5'h01;
    endfunction : move

    // edge detection on the pins, programming counter
    always @(posedge core_clk_i)
    begin
        sel_q <= sel_n_i;
        step_q <= step_i;
        vpp_q <= vpp_i;
        if (power_on_i)
        begin
            tap_o <= prog_o ? stored : 5'h10;
            pulses <= 3'h0;
        end
        else if (!lock_o)
        begin
            if (sel_q && !sel_n_i)
                up <= step_i;
            if (!sel_n_i && !step_q && step_i)
                tap_o <= move(tap_o, up);
            if (!sel_q && sel_n_i && !step_i)
                tap_o <= move(tap_o, up);
            if (vpp_i && !sel_q && sel_n_i)
                pulses <= pulses + 3'h1;
            if (vpp_q && !vpp_i)
            begin
                if (pulses >= 3'h5)
                    stored <= tap_o;
                if (pulses >= 3'h5)
                    prog_o <= 1'b1;
                if (pulses >= 3'h6)
                    lock_o <= 1'b1;
                pulses <= 3'h0;
            end
        end
    end
endmodule : pot_model
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the wiper controller against the part model
// assumes shortened wait parameters; reset doubles as the part's power-up
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic       core_clk_i  = 1'b0;
    logic       sys_rst_i   = 1'b1;
    logic       cmd_valid_i = 1'b0;
    logic [1:0] cmd_op_i    = 2'h3;
    logic       cmd_up_i    = 1'b0;
    logic [4:0] cmd_count_i = 5'h00;
    logic       cmd_ready_o;
    logic       done_o;
    logic       locked_o;
    logic       sel_n_o;
    logic       step_o;
    logic       vpp_en_o;
    logic [4:0] tap;
    logic       prog;
    logic       lock;
    int         mismatches  = 0;
    int         num_checks  = 0;
    int         sel_falls   = 0;

    // ======================================================================
    // clock, design, part model
    always #5 core_clk_i = ~core_clk_i;
    always @(negedge sel_n_o) sel_falls++;

    wiper_host #(.PUP_CYC(20), .PC_CYC(20), .CL_CYC(40), .CH_CYC(40), .PH_CYC(20)) dut_u (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_op_i(cmd_op_i), .cmd_up_i(cmd_up_i), .cmd_count_i(cmd_count_i),
        .cmd_ready_o(cmd_ready_o), .done_o(done_o), .locked_o(locked_o),
        .sel_n_o(sel_n_o), .step_o(step_o), .vpp_en_o(vpp_en_o));

    pot_model part_u (
        .core_clk_i(core_clk_i), .power_on_i(sys_rst_i), .sel_n_i(sel_n_o),
        .step_i(step_o), .vpp_i(vpp_en_o), .tap_o(tap), .prog_o(prog), .lock_o(lock));

    // ======================================================================
    // report and compare tasks
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic check_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_tap(input string what, input logic [4:0] exp, input logic [4:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check_tap

    task automatic timed_out(input string what);
        mismatches++;
        $display("BAD %s expected done seen timeout", what);
        print_verdict();
    endtask : timed_out

    // ======================================================================
    // bus helpers: reset, one command with bounded waits
    task automatic power_cycle();
        sys_rst_i = 1'b1;
        repeat (12) @(negedge core_clk_i);
        check_bit("sel_n in reset", 1'b1, sel_n_o);
        check_bit("vpp in reset", 1'b0, vpp_en_o);
        check_bit("ready in reset", 1'b0, cmd_ready_o);
        sys_rst_i = 1'b0;
    endtask : power_cycle

    task automatic run_cmd(input logic [1:0] op, input logic up, input logic [4:0] cnt);
        int i;
        for (i = 0; i < 5000 && cmd_ready_o !== 1'b1; i++)
            @(negedge core_clk_i);
        if (i == 5000)
            timed_out("ready");
        cmd_valid_i = 1'b1;
        cmd_op_i = op;
        cmd_up_i = up;
        cmd_count_i = cnt;
        @(negedge core_clk_i);
        cmd_valid_i = 1'b0;
        for (i = 0; i < 5000 && done_o !== 1'b1; i++)
            @(negedge core_clk_i);
        if (i == 5000)
            timed_out("done");
        check_bit("ready with done", 1'b1, cmd_ready_o);
        @(negedge core_clk_i);
        check_bit("done one cycle", 1'b0, done_o);
    endtask : run_cmd

    // ======================================================================
    // scenarios
    task automatic t_steps();
        check_tap("power-up tap", 5'h10, tap);
        run_cmd(potctl_pkg::OP_STEP, 1'b1, 5'h03);
        check_tap("up three", 5'h13, tap);
        run_cmd(potctl_pkg::OP_STEP, 1'b0, 5'h05);
        check_tap("down five", 5'h0e, tap);
        $display("test steps done");
    endtask : t_steps

    task automatic t_ends();
        int f;
        run_cmd(potctl_pkg::OP_STEP, 1'b1, 5'h1f);
        check_tap("top end", 5'h1f, tap);
        run_cmd(potctl_pkg::OP_STEP, 1'b0, 5'h1f);
        check_tap("bottom end", 5'h00, tap);
        run_cmd(potctl_pkg::OP_STEP, 1'b0, 5'h03);
        check_tap("below bottom", 5'h00, tap);
        f = sel_falls;
        run_cmd(potctl_pkg::OP_STEP, 1'b1, 5'h00);
        run_cmd(2'h3, 1'b1, 5'h04);
        check_bit("no select on idle ops", 1'b1, f == sel_falls);
        check_tap("idle ops hold tap", 5'h00, tap);
        $display("test ends done");
    endtask : t_ends

    task automatic t_program();
        run_cmd(potctl_pkg::OP_STEP, 1'b1, 5'h07);
        run_cmd(potctl_pkg::OP_PROG, 1'b0, 5'h00);
        check_bit("programmed", 1'b1, prog);
        check_bit("not locked", 1'b0, lock);
        check_bit("host not locked", 1'b0, locked_o);
        run_cmd(potctl_pkg::OP_STEP, 1'b1, 5'h02);
        check_tap("still adjustable", 5'h09, tap);
        power_cycle();
        check_tap("reload stored", 5'h07, tap);
        $display("test program done");
    endtask : t_program

    task automatic t_lock();
        int f;
        run_cmd(potctl_pkg::OP_LOCK, 1'b0, 5'h00);
        check_bit("part locked", 1'b1, lock);
        check_bit("host locked", 1'b1, locked_o);
        check_tap("locked tap", 5'h07, tap);
        f = sel_falls;
        run_cmd(potctl_pkg::OP_STEP, 1'b1, 5'h03);
        run_cmd(potctl_pkg::OP_PROG, 1'b0, 5'h00);
        check_bit("pins quiet when locked", 1'b1, f == sel_falls);
        check_tap("tap fixed", 5'h07, tap);
        $display("test lock done");
    endtask : t_lock

    // ======================================================================
    // main sequence
    initial
    begin
        power_cycle();
        t_steps();
        t_ends();
        t_program();
        t_lock();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
